// >>> hw/spc_cfg.svh
// constants for the serial port control field block
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
`define SPC_ADDR_CTRL 12'h000
`define SPC_ADDR_STAT 12'h004
`define SPC_ADDR_MASK 12'h008
`define SPC_ADDR_ERR 12'h00c
`define SPC_BIT_CRC_DIS 11
`define SPC_BIT_MCS_FWD 12
`define SPC_BIT_ENUM 14
`define SPC_BIT_STOP 28
`define SPC_BIT_DROP 29
`define SPC_BIT_ISO 30
`define SPC_BIT_KIND 31
`define SPC_CTRL_WMASK 32'h7000_5800
`define SPC_KIND_VAL 32'h8000_0000
`define SPC_ENUM_PORT 4'h2
`define SPC_EV_W 4
`define SPC_EV_IN_ERR 0
`define SPC_EV_DROPPED 1
`define SPC_EV_CORRUPT 2
`define SPC_EV_LOCK_RX 3
`endif

// >>> hw/spc_pkg.sv
// types for the serial port control field block
package spc_pkg;
  typedef logic [3:0] spc_port_t;
  typedef enum logic [1:0] {
    SPC_OUT_RUN = 2'b00,
    SPC_OUT_STOP = 2'b01,
    SPC_OUT_FLUSH = 2'b11
  } spc_out_e;
endpackage

// >>> hw/spc_port_ctrl.sv
// serial port control upper fields with apb slave and datapath gating
//
// The register offsets and the APB slave port are this design's own decisions.
`include "spc_cfg.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module spc_port_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire spc_pkg::spc_port_t port_num,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic maint_wr_corrupt,
  input wire logic rx_pkt_valid,
  input wire logic rx_pkt_crc_bad,
  input wire logic rx_pkt_maint,
  input wire logic rx_link_req,
  input wire logic mcs_in,
  input wire logic fab_pkt_valid,
  input wire logic tx_nack,
  input wire logic out_enable,
  input wire logic in_enable,
  input wire logic fail_thresh_async,
  input wire logic out_fail_encountered,
  output logic rx_accept,
  output logic rx_reject,
  output logic link_resp,
  output logic crc_check_on,
  output logic retransmit_en,
  output logic mcs_out,
  output logic tx_issue_en,
  output logic fab_drop,
  output logic tx_discard,
  output logic tx_flush,
  output logic rx_flush,
  output logic inbound_error,
  output logic inbound_error_stopped,
  output logic out_pkt_dropped,
  output logic irq
);
  import spc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic crc_dis;
    logic mcs_fwd;
    logic enum_b;
    logic stop_fail;
    logic drop_fail;
    logic isolate;
    logic enum_loaded;
    logic iso_prev;
    logic ofe_prev;
    spc_out_e out_st;
    logic [`SPC_EV_W-1:0] stat;
    logic [`SPC_EV_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_accept;
    logic rx_reject;
    logic link_resp;
    logic crc_check_on;
    logic retransmit_en;
    logic mcs_out;
    logic tx_issue_en;
    logic fab_drop;
    logic tx_discard;
    logic tx_flush;
    logic rx_flush;
    logic inbound_error;
    logic inbound_error_stopped;
    logic out_pkt_dropped;
    logic irq;
  } spc_state_s;

  spc_state_s r;
  spc_state_s next_r;
  logic fail_thresh;

  // threshold comes from the error-rate counter in another domain
  spc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(fail_thresh_async),
    .q(fail_thresh)
  );

  function automatic logic [31:0] ctrl_word(input spc_state_s s);
    logic [31:0] w;
    w = `SPC_KIND_VAL;
    w[`SPC_BIT_CRC_DIS] = s.crc_dis;
    w[`SPC_BIT_MCS_FWD] = s.mcs_fwd;
    w[`SPC_BIT_ENUM] = s.enum_b;
    w[`SPC_BIT_STOP] = s.stop_fail;
    w[`SPC_BIT_DROP] = s.drop_fail;
    w[`SPC_BIT_ISO] = s.isolate;
    return w;
  endfunction

  // used only for the slave error decode; the read mux decodes its own cases
  function automatic logic addr_known(input logic [11:0] a);
    return a == `SPC_ADDR_CTRL || a == `SPC_ADDR_STAT || a == `SPC_ADDR_MASK;
  endfunction

  function automatic logic lock_entry(input spc_state_s s);
    return s.isolate && !s.iso_prev;
  endfunction

  function automatic logic fail_seen(input logic ofe, input logic thr);
    return ofe || thr;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic [31:0] wd;
    logic [`SPC_EV_W-1:0] ev;
    logic rx_ok;
    logic bad_crc;
    logic dropped;
    setup = 1'b0;
    access = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wd = 32'h0;
    ev = '0;
    rx_ok = 1'b0;
    bad_crc = 1'b0;
    dropped = 1'b0;
    next_r = r;
    // a registered ready costs one cycle but keeps the answer on a flop
    // one wait state: answer on the second access cycle
    setup = psel && !penable;
    access = psel && penable && !r.pready;
    next_r.pready = access;
    next_r.pslverr = 1'b0;
    if (!access) begin
      next_r.prdata = 32'h0;
    end
    // strap caught after reset release, then software owns it
    // port_num is a static strap, so one sample is enough
    if (!r.enum_loaded) begin
      next_r.enum_b = (port_num == `SPC_ENUM_PORT);
      next_r.enum_loaded = 1'b1;
    end
    wr = access && pwrite;
    rd = access && !pwrite;
    if (wr && paddr == `SPC_ADDR_CTRL && !maint_wr_corrupt) begin
      wd = pwdata & `SPC_CTRL_WMASK;
      next_r.crc_dis = wd[`SPC_BIT_CRC_DIS];
      next_r.mcs_fwd = wd[`SPC_BIT_MCS_FWD];
      next_r.enum_b = wd[`SPC_BIT_ENUM];
      next_r.stop_fail = wd[`SPC_BIT_STOP];
      next_r.drop_fail = wd[`SPC_BIT_DROP];
      next_r.isolate = wd[`SPC_BIT_ISO];
      next_r.enum_loaded = 1'b1;
    end
    if (wr && paddr == `SPC_ADDR_MASK) begin
      next_r.mask = pwdata[`SPC_EV_W-1:0];
    end
    if (rd) begin
      case (paddr)
        `SPC_ADDR_CTRL: next_r.prdata = ctrl_word(r);
        `SPC_ADDR_STAT: next_r.prdata = {28'h0, r.stat};
        `SPC_ADDR_MASK: next_r.prdata = {28'h0, r.mask};
        default: next_r.prdata = 32'h0;
      endcase
    end
    if (access && !addr_known(paddr)) begin
      next_r.pslverr = 1'b1;
    end
    // receive path
    bad_crc = rx_pkt_valid && rx_pkt_crc_bad && !r.crc_dis;
    rx_ok = rx_pkt_valid && !r.isolate && in_enable && !bad_crc;
    if (rx_pkt_maint && bad_crc) begin
      rx_ok = 1'b0;
    end
    next_r.rx_accept = rx_ok;
    next_r.rx_reject = rx_pkt_valid && !rx_ok;
    next_r.link_resp = rx_link_req;
    next_r.inbound_error = rx_pkt_valid && r.isolate;
    next_r.inbound_error_stopped = rx_pkt_valid && r.isolate;
    next_r.crc_check_on = !r.crc_dis;
    next_r.retransmit_en = !r.crc_dis;
    next_r.mcs_out = mcs_in && r.mcs_fwd;
    // transmit path; ackid state lives elsewhere and is never touched here
    next_r.fab_drop = fab_pkt_valid && r.isolate;
    next_r.iso_prev = r.isolate;
    next_r.rx_flush = lock_entry(r);
    next_r.ofe_prev = out_fail_encountered;
    next_r.tx_flush = lock_entry(r);
    next_r.tx_discard = 1'b0;
    next_r.tx_issue_en = out_enable && !r.isolate;
    case (r.out_st)
      SPC_OUT_RUN: begin
        if (r.stop_fail && r.drop_fail && out_fail_encountered && !r.ofe_prev) begin
          next_r.out_st = SPC_OUT_FLUSH;
        end else if (r.stop_fail && !r.drop_fail &&
            fail_seen(out_fail_encountered, fail_thresh)) begin
          next_r.out_st = SPC_OUT_STOP;
        end
      end
      SPC_OUT_STOP: begin
        next_r.tx_issue_en = 1'b0;
        if (!r.stop_fail || r.drop_fail || !fail_seen(out_fail_encountered, fail_thresh)) begin
          next_r.out_st = SPC_OUT_RUN;
        end
      end
      SPC_OUT_FLUSH: begin
        // one-shot flush of stored packets, new arrivals still go out
        next_r.tx_flush = 1'b1;
        next_r.tx_discard = 1'b1;
        dropped = 1'b1;
        next_r.out_st = SPC_OUT_RUN;
      end
      default: next_r.out_st = SPC_OUT_RUN;
    endcase
    if (r.out_st == SPC_OUT_STOP) begin
      next_r.tx_issue_en = 1'b0;
    end
    if (r.drop_fail && !r.stop_fail && fail_thresh && tx_nack) begin
      next_r.tx_discard = 1'b1;
      dropped = 1'b1;
    end
    next_r.out_pkt_dropped = dropped;
    // status events: set wins over read clear
    ev[`SPC_EV_IN_ERR] = rx_pkt_valid && r.isolate;
    ev[`SPC_EV_DROPPED] = dropped;
    ev[`SPC_EV_CORRUPT] = wr && maint_wr_corrupt;
    ev[`SPC_EV_LOCK_RX] = lock_entry(r);
    if (rd && paddr == `SPC_ADDR_STAT) begin
      next_r.stat = ev;
    end else begin
      next_r.stat = r.stat | ev;
    end
    // next status feeds irq so the line rises together with the bit
    next_r.irq = |(next_r.stat & r.mask);
    if (setup) begin
      next_r.pslverr = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign rx_accept = r.rx_accept;
  assign rx_reject = r.rx_reject;
  assign link_resp = r.link_resp;
  assign crc_check_on = r.crc_check_on;
  assign retransmit_en = r.retransmit_en;
  assign mcs_out = r.mcs_out;
  assign tx_issue_en = r.tx_issue_en;
  assign fab_drop = r.fab_drop;
  assign tx_discard = r.tx_discard;
  assign tx_flush = r.tx_flush;
  assign rx_flush = r.rx_flush;
  assign inbound_error = r.inbound_error;
  assign inbound_error_stopped = r.inbound_error_stopped;
  assign out_pkt_dropped = r.out_pkt_dropped;
  assign irq = r.irq;
endmodule

// >>> hw/spc_sync.sv
// three-stage synchroniser for a level from outside the clock domain
module spc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic [2:0] sh;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh <= 3'h0;
      q <= 1'b0;
    end else begin
      sh <= {sh[1:0], d};
      // change counts once the second and third stages agree
      if (sh[1] == sh[2]) begin
        q <= sh[2];
      end
    end
  end
endmodule

// >>> verif/spc_partner.sv
// link partner model
module spc_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire logic rx_reject,
  output logic rx_pkt_valid,
  output logic out_err,
  output logic out_err_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  assign rx_pkt_valid = send;
  // sticky until reset, so a later check still sees an earlier reject
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_err <= 1'b0;
      out_err_stop <= 1'b0;
    end else if (rx_reject) begin
      out_err <= 1'b1;
      out_err_stop <= 1'b1;
    end
  end
endmodule

// >>> verif/spc_port_ctrl_monitor.sv
// assertion checker for the port control block
module spc_port_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_pkt_valid,
  input wire logic rx_pkt_crc_bad,
  input wire logic rx_pkt_maint,
  input wire logic rx_link_req,
  input wire logic in_enable,
  input wire logic mcs_in,
  input wire logic fab_pkt_valid,
  input wire logic crc_check_on,
  input wire logic retransmit_en,
  input wire logic rx_accept,
  input wire logic rx_reject,
  input wire logic link_resp,
  input wire logic mcs_out,
  input wire logic fab_drop,
  input wire logic inbound_error,
  input wire logic inbound_error_stopped
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_access;
    psel && penable && !pready ##1 pready;
  endsequence
  chk_answer_next: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  chk_answer_once: assert property (pready |=> !pready)
    else $error("answer held too long");
  chk_ctrl_read: assert property (s_access ##0 (!pwrite && paddr == 12'h000) |->
    prdata[31] && prdata[27:15] == 13'h0 && !prdata[13]) else $error("bad fixed bits");
  chk_unmapped_err: assert property (s_access ##0 (!pwrite && paddr > 12'h00c) |->
    pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  chk_retx_pair: assert property (crc_check_on == retransmit_en)
    else $error("retransmit differs from checking");
  chk_crc_reject: assert property (crc_check_on && rx_pkt_valid && rx_pkt_crc_bad &&
    rx_pkt_maint |=> rx_reject && !rx_accept) else $error("corrupt packet accepted");
  chk_mcs_cause: assert property (mcs_out |-> $past(mcs_in))
    else $error("event symbol without input");
  chk_reject_cause: assert property (rx_reject |-> $past(rx_pkt_valid) && !rx_accept)
    else $error("reject without packet");
  chk_inerr_pair: assert property (inbound_error |-> inbound_error_stopped &&
    $past(rx_pkt_valid)) else $error("inbound error flags apart");
  chk_fab_cause: assert property (fab_drop |-> $past(fab_pkt_valid))
    else $error("drop without fabric packet");
  chk_link_answer: assert property (rx_link_req && in_enable |=> link_resp)
    else $error("link request unanswered");
endmodule
bind spc_port_ctrl spc_port_ctrl_monitor i_spc_port_ctrl_monitor (.*);

// >>> verif/tb_top.sv
// testbench for the port control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, maint_wr_corrupt = 0;
  logic rx_pkt_crc_bad = 0, rx_pkt_maint = 0, out_enable = 1, in_enable = 1, hit;
  logic fail_thresh_async = 0, out_fail_encountered = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [4:0] pul = 5'h0;
  spc_port_t port_num = 4'h2;
  logic send, rx_link_req, mcs_in, fab_pkt_valid, tx_nack, rx_pkt_valid, rx_accept, rx_reject;
  logic link_resp, crc_check_on, retransmit_en, mcs_out, tx_issue_en, fab_drop, tx_discard;
  logic tx_flush, rx_flush, inbound_error, inbound_error_stopped, out_pkt_dropped, irq;
  logic out_err, out_err_stop;
  int fail_count = 0, comparisons = 0;
  assign {send, rx_link_req, mcs_in, fab_pkt_valid, tx_nack} = pul;
  always #5 pclk = ~pclk;
  spc_port_ctrl i_spc_port_ctrl (.*);
  spc_partner i_spc_partner (.*);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge pclk);
    pul <= v;
    @(posedge pclk);
    pul <= 5'h0;
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc(12'h000, 32'h8000_4000);
    apb(1'b1, 12'h000, 32'hffff_ffff);
    rdc(12'h000, 32'hf000_5800);
    apb(1'b1, 12'h000, 32'h0);
    rdc(12'h000, 32'h8000_0000);
    rdc(12'h004, 32'h8);
    maint_wr_corrupt <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_1000);
    maint_wr_corrupt <= 1'b0;
    rdc(12'h000, 32'h8000_0000);
    rdc(12'h004, 32'h4);
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("register test done");
    pulse(5'h04);
    chk(mcs_out, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_1800);
    #1;
    chk({crc_check_on, retransmit_en}, 2'h0);
    pulse(5'h04);
    chk(mcs_out, 1'b1);
    $display("forward test done");
    apb(1'b1, 12'h008, 32'hf);
    apb(1'b1, 12'h000, 32'h4000_0000);
    #1;
    chk(tx_issue_en, 1'b0);
    chk({rx_flush, tx_flush}, 2'h3);
    pulse(5'h10);
    chk({rx_reject, inbound_error, inbound_error_stopped}, 3'h7);
    pulse(5'h02);
    chk(fab_drop, 1'b1);
    chk({out_err, out_err_stop}, 2'h3);
    pulse(5'h08);
    chk(link_resp, 1'b1);
    chk(irq, 1'b1);
    rdc(12'h004, 32'h9);
    repeat (2) @(posedge pclk);
    #1;
    chk(irq, 1'b0);
    apb(1'b1, 12'h000, 32'h0);
    out_enable <= 1'b0;
    rx_pkt_crc_bad <= 1'b1;
    rx_pkt_maint <= 1'b1;
    pulse(5'h10);
    chk({rx_accept, rx_reject, tx_issue_en}, 3'h2);
    $display("lockout test done");
    @(posedge pclk);
    out_enable <= 1'b1;
    rx_pkt_crc_bad <= 1'b0;
    pulse(5'h10);
    chk({rx_accept, rx_reject, tx_issue_en}, 3'h5);
    apb(1'b1, 12'h000, 32'h2000_0000);
    fail_thresh_async <= 1'b1;
    repeat (6) @(posedge pclk);
    pulse(5'h01);
    chk({tx_discard, out_pkt_dropped}, 2'h3);
    @(posedge pclk);
    fail_thresh_async <= 1'b0;
    repeat (6) @(posedge pclk);
    pulse(5'h01);
    chk(tx_discard, 1'b0);
    apb(1'b1, 12'h000, 32'h1000_0000);
    out_fail_encountered <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk(tx_issue_en, 1'b0);
    @(posedge pclk);
    out_fail_encountered <= 1'b0;
    apb(1'b1, 12'h000, 32'h3000_0000);
    out_fail_encountered <= 1'b1;
    hit = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      #1;
      hit |= tx_flush;
    end
    chk(hit, 1'b1);
    $display("fail mode test done");
    @(posedge pclk);
    presetn <= 1'b0;
    port_num <= 4'h3;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc(12'h000, 32'h8000_0000);
    $display("reset test done");
    print_verdict();
  end
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule
